// [hdl/ifod_decoder.sv]
// Top-level instruction format and operand decoder with effective address forming.
`timescale 1ns/1ps
`default_nettype none

module ifod_decoder
    import ifod_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic insn_valid,
    input wire logic [15:0] insn_word,
    input wire ifod_fmt_type insn_fmt,
    input wire ifod_ea_type ea_mode,
    input wire ifod_imm_type imm_kind,
    input wire logic [1:0] op_size,
    input wire logic ea_on_src,
    input wire logic [31:0] pc_value,
    input wire logic [31:0] source_register_value,
    input wire logic [31:0] dest_register_value,
    input wire logic [31:0] index_register_zero_value,
    input wire logic [31:0] global_base_pointer_value,
    output logic dec_valid_q,
    output logic [15:0] opcode_bits_q,
    output logic [3:0] source_register_q,
    output logic [3:0] dest_register_q,
    output logic [31:0] imm_value_q,
    output logic [31:0] eff_addr_q,
    output logic [31:0] eff_addr2_q,
    output logic [31:0] src_ptr_next_q,
    output logic [31:0] dst_ptr_next_q,
    output logic src_ptr_wb_q,
    output logic dst_ptr_wb_q,
    output logic accum_dest_q
);
    logic rst_sync1_q;
    logic rst_n_q;
    logic has_hi_reg;
    logic has_mid_reg;
    logic hi_is_src;
    logic mid_is_src;
    logic [3:0] hi_field;
    logic [3:0] mid_field;
    logic [3:0] src_sel_d;
    logic [3:0] dst_sel_d;
    logic [15:0] opcode_mask;
    logic [11:0] disp_raw;
    logic disp_long;
    logic disp_sign;
    logic [1:0] disp_size;
    logic [31:0] disp_scaled;
    logic [31:0] step;
    logic [31:0] base;
    logic [31:0] imm_d;
    logic [31:0] ea_d;
    logic [31:0] ea2_d;
    logic [31:0] src_next_d;
    logic [31:0] dst_next_d;
    logic src_wb_d;
    logic dst_wb_d;
    logic chk_en;

    // Reset is released through two flops so the release is clean against ref_clk.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_sync1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_sync1_q <= 1'b1;
            rst_n_q <= rst_sync1_q;
        end
    end

    // Field roles per format; formats without a field leave its selector at register zero.
    assign hi_field = insn_word[IFOD_HI_REG_LSB +: IFOD_NIB_W];
    assign mid_field = insn_word[IFOD_MID_REG_LSB +: IFOD_NIB_W];
    assign has_hi_reg = (insn_fmt == IFOD_FMT_N) || (insn_fmt == IFOD_FMT_M) || (insn_fmt == IFOD_FMT_NM) ||
                        (insn_fmt == IFOD_FMT_NMD) || (insn_fmt == IFOD_FMT_ND8) || (insn_fmt == IFOD_FMT_NI);
    assign has_mid_reg = (insn_fmt == IFOD_FMT_NM) || (insn_fmt == IFOD_FMT_NMD) ||
                         (insn_fmt == IFOD_FMT_MD) || (insn_fmt == IFOD_FMT_ND4);
    assign hi_is_src = (insn_fmt == IFOD_FMT_M);
    assign mid_is_src = (insn_fmt != IFOD_FMT_ND4);
    assign src_sel_d = (has_hi_reg && hi_is_src) ? hi_field : (has_mid_reg && mid_is_src) ? mid_field : IFOD_INDEX_REG;
    assign dst_sel_d = (has_hi_reg && !hi_is_src) ? hi_field :
                       (has_mid_reg && !mid_is_src) ? mid_field : IFOD_INDEX_REG;

    // Opcode mask keeps only the opcode bits of the word.
    assign opcode_mask = (insn_fmt == IFOD_FMT_ZERO) ? 16'hffff :
                         (insn_fmt == IFOD_FMT_N || insn_fmt == IFOD_FMT_M) ? 16'hf0ff :
                         (insn_fmt == IFOD_FMT_NM) ? 16'hf00f :
                         (insn_fmt == IFOD_FMT_MD || insn_fmt == IFOD_FMT_ND4 ||
                          insn_fmt == IFOD_FMT_D || insn_fmt == IFOD_FMT_I) ? 16'hff00 : 16'hf000;

    // Displacement source: twelve bits for d12, a byte for d and nd8, a nibble otherwise.
    assign disp_long = (insn_fmt == IFOD_FMT_D12);
    assign disp_raw = disp_long ? insn_word[IFOD_D12_W-1:0] :
                      (insn_fmt == IFOD_FMT_D || insn_fmt == IFOD_FMT_ND8) ?
                      {4'h0, insn_word[IFOD_BYTE_W-1:0]} : {8'h00, insn_word[IFOD_LO_NIB_LSB +: IFOD_NIB_W]};
    // Branch offsets count instructions, so they are signed and scaled as words.
    assign disp_sign = (ea_mode == IFOD_EA_PC_BRANCH);
    assign disp_size = disp_sign ? IFOD_SZ_WORD : op_size;

    ifod_disp_scale u_scale (
        .disp_raw(disp_raw),
        .is_long_field(disp_long),
        .sign_ext(disp_sign),
        .size(disp_size),
        .disp_scaled(disp_scaled)
    );

    // Immediate extension chosen by the opcode class.
    assign imm_d = (imm_kind == IFOD_IMM_SIGN) ? {{24{insn_word[7]}}, insn_word[7:0]} :
                   (imm_kind == IFOD_IMM_TRAP) ? ({24'h000000, insn_word[7:0]} << IFOD_TRAP_SHIFT) :
                   {24'h000000, insn_word[7:0]};

    assign step = ifod_size_step(op_size);
    assign base = ea_on_src ? source_register_value : dest_register_value;

    // Effective address per mode; pointer write-backs go to the register that supplied the base.
    always_comb
    begin
        ea_d = IFOD_WORD_RST;
        ea2_d = IFOD_WORD_RST;
        src_next_d = source_register_value;
        dst_next_d = dest_register_value;
        src_wb_d = 1'b0;
        dst_wb_d = 1'b0;
        case (ea_mode)
            IFOD_EA_REG_IND: ea_d = base;
            IFOD_EA_POSTINC:
            begin
                ea_d = base;
                src_next_d = source_register_value + step;
                dst_next_d = dest_register_value + step;
                src_wb_d = ea_on_src;
                dst_wb_d = !ea_on_src;
            end
            IFOD_EA_PREDEC:
            begin
                ea_d = base - step;
                src_next_d = source_register_value - step;
                dst_next_d = dest_register_value - step;
                src_wb_d = ea_on_src;
                dst_wb_d = !ea_on_src;
            end
            IFOD_EA_DISP_REG: ea_d = base + disp_scaled;
            IFOD_EA_INDEXED: ea_d = base + index_register_zero_value;
            IFOD_EA_GBR_DISP: ea_d = global_base_pointer_value + disp_scaled;
            IFOD_EA_GBR_IDX: ea_d = global_base_pointer_value + index_register_zero_value;
            IFOD_EA_PC_DISP: ea_d = pc_value + disp_scaled;
            IFOD_EA_PC_REG: ea_d = pc_value + source_register_value;
            IFOD_EA_PC_BRANCH: ea_d = pc_value + disp_scaled;
            IFOD_EA_MAC:
            begin
                ea_d = source_register_value;
                ea2_d = dest_register_value;
                src_next_d = source_register_value + step;
                dst_next_d = dest_register_value + step;
                src_wb_d = 1'b1;
                dst_wb_d = 1'b1;
            end
            default: ea_d = IFOD_WORD_RST;
        endcase
    end

    // Single output stage; clk_en freezes everything.
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            dec_valid_q <= 1'b0;
            opcode_bits_q <= 16'h0000;
            source_register_q <= IFOD_SEL_RST;
            dest_register_q <= IFOD_SEL_RST;
            imm_value_q <= IFOD_WORD_RST;
            eff_addr_q <= IFOD_WORD_RST;
            eff_addr2_q <= IFOD_WORD_RST;
            src_ptr_next_q <= IFOD_WORD_RST;
            dst_ptr_next_q <= IFOD_WORD_RST;
            src_ptr_wb_q <= 1'b0;
            dst_ptr_wb_q <= 1'b0;
            accum_dest_q <= 1'b0;
        end
        else if (clk_en)
        begin
            dec_valid_q <= insn_valid;
            opcode_bits_q <= insn_word & opcode_mask;
            source_register_q <= src_sel_d;
            dest_register_q <= dst_sel_d;
            imm_value_q <= imm_d;
            eff_addr_q <= ea_d;
            eff_addr2_q <= ea2_d;
            src_ptr_next_q <= src_next_d;
            dst_ptr_next_q <= dst_next_d;
            src_ptr_wb_q <= insn_valid & src_wb_d;
            dst_ptr_wb_q <= insn_valid & dst_wb_d;
            accum_dest_q <= insn_valid & (ea_mode == IFOD_EA_MAC);
        end
    end

    // Checks tie registered outputs other than opcode_bits_q, eff_addr2_q, src_ptr_next_q and dec_valid_q to the inputs of the previous enabled cycle.
    // The reset-release edge loads nothing even with the enable high, so it never arms a check.
    assign chk_en = clk_en & rst_n_q;
    property p_pc_reg;
        @(posedge ref_clk) disable iff (!rst_n_q)
        (chk_en && ea_mode == IFOD_EA_PC_REG) |=> (eff_addr_q == $past(pc_value) + $past(source_register_value));
    endproperty
    a_pc_reg: assert property (p_pc_reg) else $error("PC plus register address wrong.");

    property p_imm_zero;
        @(posedge ref_clk) disable iff (!rst_n_q)
        (chk_en && imm_kind == IFOD_IMM_ZERO) |=> (imm_value_q == {24'h000000, $past(insn_word[7:0])});
    endproperty
    a_imm_zero: assert property (p_imm_zero) else $error("Zero-extended immediate wrong.");

    property p_imm_sign;
        @(posedge ref_clk) disable iff (!rst_n_q)
        (chk_en && imm_kind == IFOD_IMM_SIGN) |=> (imm_value_q == {{24{$past(insn_word[7])}}, $past(insn_word[7:0])});
    endproperty
    a_imm_sign: assert property (p_imm_sign) else $error("Sign-extended immediate wrong.");

    property p_imm_trap;
        @(posedge ref_clk) disable iff (!rst_n_q)
        (chk_en && imm_kind == IFOD_IMM_TRAP) |=> (imm_value_q == {22'h000000, $past(insn_word[7:0]), 2'b00});
    endproperty
    a_imm_trap: assert property (p_imm_trap) else $error("Trap vector offset wrong.");

    property p_gbr_long;
        @(posedge ref_clk) disable iff (!rst_n_q)
        (chk_en && ea_mode == IFOD_EA_GBR_DISP && op_size == IFOD_SZ_LONG && insn_fmt == IFOD_FMT_D)
        |=> (eff_addr_q == $past(global_base_pointer_value) + {22'h000000, $past(insn_word[7:0]), 2'b00});
    endproperty
    a_gbr_long: assert property (p_gbr_long) else $error("Global-base longword address wrong.");

    property p_md_fields;
        @(posedge ref_clk) disable iff (!rst_n_q)
        (chk_en && insn_fmt == IFOD_FMT_MD) |=> source_register_q == $past(insn_word[7:4]) && dest_register_q == 4'h0;
    endproperty
    a_md_fields: assert property (p_md_fields) else $error("md field split wrong.");

    property p_nd4_fields;
        @(posedge ref_clk) disable iff (!rst_n_q)
        (chk_en && insn_fmt == IFOD_FMT_ND4)
        |=> (dest_register_q == $past(insn_word[7:4]) && source_register_q == 4'h0);
    endproperty
    a_nd4_fields: assert property (p_nd4_fields) else $error("nd4 field split wrong.");

    property p_predec;
        @(posedge ref_clk) disable iff (!rst_n_q)
        (chk_en && insn_valid && ea_mode == IFOD_EA_PREDEC && !ea_on_src && op_size == IFOD_SZ_WORD)
        |=> (eff_addr_q == $past(dest_register_value) - 32'h0000_0002 && dst_ptr_wb_q && dst_ptr_next_q == eff_addr_q);
    endproperty
    a_predec: assert property (p_predec) else $error("Pre-decrement address wrong.");

    property p_mac;
        @(posedge ref_clk) disable iff (!rst_n_q)
        (chk_en && insn_valid && ea_mode == IFOD_EA_MAC) |=> (accum_dest_q && src_ptr_wb_q && dst_ptr_wb_q);
    endproperty
    a_mac: assert property (p_mac) else $error("Multiply-accumulate pointers not both updated.");

    property p_freeze;
        @(posedge ref_clk) disable iff (!rst_n_q)
        !clk_en |=> $stable(eff_addr_q) && $stable(dec_valid_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("State changed while clock enable low.");
endmodule : ifod_decoder

`default_nettype wire

// [hdl/ifod_pkg_scale.sv]
// Shared package for the instruction operand decoder, and its displacement extend-and-scale unit.
`timescale 1ns/1ps
`default_nettype none

package ifod_pkg;
    // Field positions inside the 16-bit instruction word.
    localparam int IFOD_HI_REG_LSB = 8;
    localparam int IFOD_MID_REG_LSB = 4;
    localparam int IFOD_LO_NIB_LSB = 0;
    localparam int IFOD_NIB_W = 4;
    localparam int IFOD_BYTE_W = 8;
    localparam int IFOD_D12_W = 12;
    localparam int IFOD_DATA_W = 32;
    // Operand size codes.
    localparam logic [1:0] IFOD_SZ_BYTE = 2'h0;
    localparam logic [1:0] IFOD_SZ_WORD = 2'h1;
    localparam logic [1:0] IFOD_SZ_LONG = 2'h2;
    // Left shift applied to the trap immediate, a multiplier of four.
    localparam logic [1:0] IFOD_TRAP_SHIFT = 2'h2;
    // Reset values and the index register number.
    localparam logic [31:0] IFOD_WORD_RST = 32'h0000_0000;
    localparam logic [3:0] IFOD_SEL_RST = 4'h0;
    localparam logic [3:0] IFOD_INDEX_REG = 4'h0;

    typedef enum logic [3:0] {
        IFOD_FMT_ZERO, IFOD_FMT_N, IFOD_FMT_M, IFOD_FMT_NM, IFOD_FMT_MD, IFOD_FMT_ND4,
        IFOD_FMT_NMD, IFOD_FMT_D, IFOD_FMT_D12, IFOD_FMT_ND8, IFOD_FMT_I, IFOD_FMT_NI
    } ifod_fmt_type;

    typedef enum logic [3:0] {
        IFOD_EA_NONE, IFOD_EA_REG_IND, IFOD_EA_POSTINC, IFOD_EA_PREDEC, IFOD_EA_DISP_REG,
        IFOD_EA_INDEXED, IFOD_EA_GBR_DISP, IFOD_EA_GBR_IDX, IFOD_EA_PC_DISP, IFOD_EA_PC_REG,
        IFOD_EA_PC_BRANCH, IFOD_EA_MAC
    } ifod_ea_type;

    typedef enum logic [1:0] {
        IFOD_IMM_ZERO, IFOD_IMM_SIGN, IFOD_IMM_TRAP
    } ifod_imm_type;

    // Byte step of one operand, used by post-increment and pre-decrement.
    function automatic logic [31:0] ifod_size_step(input logic [1:0] size);
        logic [31:0] step;
        step = 32'h0000_0001;
        if (size == IFOD_SZ_WORD)
        begin
            step = 32'h0000_0002;
        end
        else if (size == IFOD_SZ_LONG)
        begin
            step = 32'h0000_0004;
        end
        return step;
    endfunction : ifod_size_step
endpackage : ifod_pkg

// Extends a raw displacement (zero or sign) and scales it by the operand size.
module ifod_disp_scale
    import ifod_pkg::*;
(
    input wire logic [11:0] disp_raw,
    input wire logic is_long_field,
    input wire logic sign_ext,
    input wire logic [1:0] size,
    output logic [31:0] disp_scaled
);
    logic sign_bit;
    logic [31:0] disp_ext;

    // Sign bit sits at bit 11 for the long branch field, bit 7 otherwise.
    assign sign_bit = sign_ext & (is_long_field ? disp_raw[11] : disp_raw[7]);
    assign disp_ext = is_long_field ? {{20{sign_bit}}, disp_raw} : {{24{sign_bit}}, disp_raw[7:0]};
    // Scaling is a shift, so a size of three is treated as longword.
    assign disp_scaled = (size == IFOD_SZ_BYTE) ? disp_ext :
                         (size == IFOD_SZ_WORD) ? {disp_ext[30:0], 1'b0} : {disp_ext[29:0], 2'b00};
endmodule : ifod_disp_scale

`default_nettype wire

// [test/ifod_regfile_model.sv]
// Execute-side partner model: register file, program counter and global base pointer.
`timescale 1ns/1ps
`default_nettype none
module ifod_regfile_model
    import ifod_pkg::*;
(
    input wire logic ref_clk,
    input wire logic clk_en,
    input wire logic [3:0] src_sel,
    input wire logic [3:0] dst_sel,
    input wire logic [3:0] src_wb_sel,
    input wire logic [3:0] dst_wb_sel,
    input wire logic src_wb,
    input wire logic dst_wb,
    input wire logic [31:0] src_next,
    input wire logic [31:0] dst_next,
    output logic [31:0] pc_value,
    output logic [31:0] src_value,
    output logic [31:0] dst_value,
    output logic [31:0] zero_value,
    output logic [31:0] base_value
);
    logic [31:0] regs [16];
    // A spread start pattern keeps every selector distinguishable at the decoder inputs.
    initial
    begin
        for (int i = 0; i < 16; i++)
        begin
            regs[i] = 32'h1357_9bdf * (i + 1);
        end
        pc_value = 32'h0000_4000;
    end
    // Operand reads are combinational, like a register file read port.
    assign base_value = 32'h0800_0100;
    assign src_value = regs[src_sel];
    assign dst_value = regs[dst_sel];
    assign zero_value = regs[0];
    // Pointer write-back lands once, on the next enabled edge; the destination wins a collision.
    always @(posedge ref_clk)
    begin
        if (clk_en)
        begin
            pc_value <= pc_value + 32'h0000_0002;
            if (src_wb)
                regs[src_wb_sel] <= src_next;
            if (dst_wb)
                regs[dst_wb_sel] <= dst_next;
        end
    end
endmodule : ifod_regfile_model
`default_nettype wire

// [test/tb_ifod_decoder.sv]
// Self-checking testbench for the operand decoder against a behavioural model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("ERROR t=%0t got %h expected %h", $time, got, exp); \
        end \
    end
module tb_ifod_decoder
    import ifod_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b0;
    logic insn_valid = 1'b0;
    logic [15:0] insn_word = 16'h0000;
    ifod_fmt_type insn_fmt = IFOD_FMT_ZERO;
    ifod_ea_type ea_mode = IFOD_EA_NONE;
    ifod_imm_type imm_kind = IFOD_IMM_ZERO;
    logic [1:0] op_size = 2'h0;
    logic ea_on_src = 1'b0;
    logic [3:0] src_sel = 4'h0;
    logic [3:0] dst_sel = 4'h0;
    logic [31:0] pc_v, sv, dv, r0v, gbv;
    logic dec_valid_q, src_ptr_wb_q, dst_ptr_wb_q, accum_dest_q;
    logic [15:0] opcode_bits_q;
    logic [3:0] source_register_q, dest_register_q;
    logic [31:0] imm_value_q, eff_addr_q, eff_addr2_q, src_ptr_next_q, dst_ptr_next_q;
    // Expected outputs; they hold across disabled edges just as the design's outputs do.
    logic [31:0] e_imm = 32'h0, e_ea = 32'h0, e_ea2 = 32'h0, e_sn = 32'h0, e_dn = 32'h0;
    logic [15:0] e_op = 16'h0;
    logic [3:0] e_s = 4'h0, e_d = 4'h0;
    logic e_v = 1'b0, e_sw = 1'b0, e_dw = 1'b0, e_acc = 1'b0, e_ci = 1'b0, e_ce = 1'b0;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;
    // Legal {format, mode, base-is-source} triples in enum order; random pairs would be meaningless.
    logic [11:0] combo [24] = '{12'h001, 12'h100, 12'h130, 12'h201, 12'h221, 12'h211, 12'h291, 12'h310,
        12'h321, 12'h330, 12'h350, 12'h3b1, 12'h441, 12'h540, 12'h640, 12'h641, 12'h761, 12'h781,
        12'h7a1, 12'h8a1, 12'h981, 12'ha71, 12'ha01, 12'hb01};

    always #25 ref_clk = ~ref_clk;

    ifod_decoder i_ifod_decoder (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
        .insn_valid(insn_valid), .insn_word(insn_word), .insn_fmt(insn_fmt), .ea_mode(ea_mode),
        .imm_kind(imm_kind), .op_size(op_size), .ea_on_src(ea_on_src), .pc_value(pc_v),
        .source_register_value(sv), .dest_register_value(dv), .index_register_zero_value(r0v),
        .global_base_pointer_value(gbv), .dec_valid_q(dec_valid_q), .opcode_bits_q(opcode_bits_q),
        .source_register_q(source_register_q), .dest_register_q(dest_register_q),
        .imm_value_q(imm_value_q), .eff_addr_q(eff_addr_q), .eff_addr2_q(eff_addr2_q),
        .src_ptr_next_q(src_ptr_next_q), .dst_ptr_next_q(dst_ptr_next_q),
        .src_ptr_wb_q(src_ptr_wb_q), .dst_ptr_wb_q(dst_ptr_wb_q), .accum_dest_q(accum_dest_q));

    ifod_regfile_model i_ifod_regfile_model (.ref_clk(ref_clk), .clk_en(clk_en), .src_sel(src_sel),
        .dst_sel(dst_sel), .src_wb_sel(source_register_q), .dst_wb_sel(dest_register_q),
        .src_wb(src_ptr_wb_q), .dst_wb(dst_ptr_wb_q), .src_next(src_ptr_next_q),
        .dst_next(dst_ptr_next_q), .pc_value(pc_v), .src_value(sv), .dst_value(dv),
        .zero_value(r0v), .base_value(gbv));

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // Works out every output from the rules and the current inputs.
    task automatic predict(input logic [11:0] c);
        logic [31:0] sc, base, nx;
        logic [3:0] f;
        logic mac, step_mode;
        f = c[11:8];
        sc = (op_size == IFOD_SZ_BYTE) ? 32'h1 : ((op_size == IFOD_SZ_WORD) ? 32'h2 : 32'h4);
        base = c[0] ? sv : dv;
        mac = ea_mode == IFOD_EA_MAC;
        step_mode = ea_mode inside {IFOD_EA_POSTINC, IFOD_EA_PREDEC};
        nx = (ea_mode == IFOD_EA_POSTINC) ? base + sc : base - sc;
        e_v = insn_valid;
        e_s = src_sel;
        e_d = dst_sel;
        e_ci = f inside {4'ha, 4'hb};
        e_ce = c[7:4] != 4'h0;
        e_acc = mac;
        e_ea2 = mac ? dv : 32'h0;
        e_sw = insn_valid && (mac || (step_mode && c[0]));
        e_dw = insn_valid && (mac || (step_mode && !c[0]));
        e_sn = mac ? sv + sc : nx;
        e_dn = mac ? dv + sc : nx;
        e_imm = {24'h0, insn_word[7:0]};
        if (imm_kind == IFOD_IMM_SIGN)
            e_imm = {{24{insn_word[7]}}, insn_word[7:0]};
        if (imm_kind == IFOD_IMM_TRAP)
            e_imm = {22'h0, insn_word[7:0], 2'h0};
        case (f)
            4'h0: e_op = insn_word;
            4'h1, 4'h2: e_op = insn_word & 16'hf0ff;
            4'h3: e_op = insn_word & 16'hf00f;
            4'h4, 4'h5, 4'h7, 4'ha: e_op = insn_word & 16'hff00;
            default: e_op = insn_word & 16'hf000;
        endcase
        case (ea_mode)
            IFOD_EA_PREDEC: e_ea = base - sc;
            IFOD_EA_DISP_REG: e_ea = base + {28'h0, insn_word[3:0]} * sc;
            IFOD_EA_INDEXED: e_ea = base + r0v;
            IFOD_EA_GBR_DISP: e_ea = gbv + {24'h0, insn_word[7:0]} * sc;
            IFOD_EA_GBR_IDX: e_ea = gbv + r0v;
            IFOD_EA_PC_DISP: e_ea = pc_v + {24'h0, insn_word[7:0]} * sc;
            IFOD_EA_PC_REG: e_ea = pc_v + sv;
            IFOD_EA_PC_BRANCH: e_ea = pc_v + ((f == 4'h7) ? {{23{insn_word[7]}}, insn_word[7:0], 1'b0}
                : {{19{insn_word[11]}}, insn_word[11:0], 1'b0});
            IFOD_EA_MAC: e_ea = sv;
            default: e_ea = base;
        endcase
    endtask : predict

    // Fields other than the valid copy and write-back flags are only judged for valid words.
    task automatic check();
        `CHK(dec_valid_q, e_v)
        `CHK(src_ptr_wb_q, e_sw)
        `CHK(dst_ptr_wb_q, e_dw)
        if (e_v)
        begin
            `CHK(opcode_bits_q, e_op)
            `CHK(source_register_q, e_s)
            `CHK(dest_register_q, e_d)
            `CHK(eff_addr2_q, e_ea2)
            `CHK(accum_dest_q, e_acc)
            if (e_ci)
                `CHK(imm_value_q, e_imm)
            if (e_ce)
                `CHK(eff_addr_q, e_ea)
            if (e_sw)
                `CHK(src_ptr_next_q, e_sn)
            if (e_dw)
                `CHK(dst_ptr_next_q, e_dn)
        end
    endtask : check

    // Cuts a hang short; the run needs under nine hundred cycles.
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // Every combination first with the clock enabled, then random combinations and stalls; words and sizes are random throughout.
    initial
    begin
        logic [11:0] c;
        logic [3:0] f;
        void'($urandom(32'h4a26));
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge ref_clk);
        for (int n = 0; n < 800; n++)
        begin
            @(negedge ref_clk);
            check();
            // Mid-run reset with enable and valid high: outputs must stay clear through the release edges.
            if (n == 400)
            begin
                rst_b = 1'b0;
                clk_en = 1'b1;
                insn_valid = 1'b1;
                @(negedge ref_clk);
                rst_b = 1'b1;
                repeat (2) @(negedge ref_clk);
                `CHK({dec_valid_q, src_ptr_wb_q, dst_ptr_wb_q, accum_dest_q, opcode_bits_q}, 20'h0)
                `CHK({source_register_q, dest_register_q, imm_value_q, eff_addr_q}, 72'h0)
                `CHK({eff_addr2_q, src_ptr_next_q, dst_ptr_next_q}, 96'h0)
                e_v = 1'b0;
                e_sw = 1'b0;
                e_dw = 1'b0;
            end
            c = combo[(n < 24) ? n : ($urandom % 24)];
            f = c[11:8];
            clk_en = (n < 48) || (($urandom % 8) != 0);
            insn_valid = (n < 48) || (($urandom % 6) != 0);
            insn_word = 16'($urandom);
            insn_fmt = ifod_fmt_type'(f);
            ea_mode = ifod_ea_type'(c[7:4]);
            ea_on_src = c[0];
            imm_kind = ifod_imm_type'(n % 3);
            op_size = 2'($urandom % 3);
            src_sel = (f == 4'h2) ? insn_word[11:8] : ((f inside {4'h3, 4'h4, 4'h6}) ? insn_word[7:4] : 4'h0);
            dst_sel = (f inside {4'h1, 4'h3, 4'h6, 4'h9, 4'hb}) ? insn_word[11:8]
                : ((f == 4'h5) ? insn_word[7:4] : 4'h0);
            #1;
            if (clk_en)
                predict(c);
        end
        @(negedge ref_clk);
        check();
        end_of_test();
    end
endmodule : tb_ifod_decoder
`default_nettype wire
